// ### sma_cfg.svh
// Timing and framing constants shared by both ends of the serial link.
// Assumes inclusion by bare name; holds definitions only.
`ifndef SMA_CFG_SVH
`define SMA_CFG_SVH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define SMA_ADDR_BITS      7
`define SMA_DATA_BITS      8
`define SMA_FRAME_BITS     16
`define SMA_DIR_READ       1'b1
`define SMA_DIR_WRITE      1'b0

// ----------------------------------------------------------------
// Link clock divider for the master; slave register reset value
// ----------------------------------------------------------------
`define SMA_HALF_DIV       5
`define SMA_REG_RESET      8'h00

`endif

// ### sma_pkg.sv
// Types used by the master end of the serial register link.
// Assumes sma_cfg.svh for widths.
`include "sma_cfg.svh"

package sma_pkg;
    // Command that the user side hands to the master
    typedef struct packed {
        logic       rd;
        logic [6:0] addr;
        logic [7:0] data;
    } sma_cmd_t;
endpackage

// ### sma_if.sv
// Interface that carries the four serial wires between the two ends.
// Assumes both ends sample it on their own clocks.
`timescale 1ns/100ps
`default_nettype none

interface sma_if;
    logic sclk;
    logic cs_b;
    logic mosi;
    logic miso;
    logic miso_oe;

    modport master (
        output sclk,
        output cs_b,
        output mosi,
        input  miso
    );
    modport slave (
        input  sclk,
        input  cs_b,
        input  mosi,
        output miso,
        output miso_oe
    );
endinterface

`default_nettype wire

// ### sma_fifo.sv
// Small valid/ready FIFO used in the master's command path.
// Assumes one clock domain.
`timescale 1ns/100ps
`default_nettype none

module sma_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [AW:0]      cnt_reg;
    logic             push;
    logic             pop;

    // ----------------------------------------------------------------
    // Handshakes
    // ----------------------------------------------------------------
    assign in_ready_o  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o  = mem_reg[rd_reg];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Storage has no reset; only pointers matter
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data_i;
        end
    end

    // Pointers wrap; depth is assumed a power of two
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= push ? wr_reg + 1'b1 : wr_reg;
            rd_reg  <= pop ? rd_reg + 1'b1 : rd_reg;
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

`default_nettype wire

// ### sma_slave.sv
// Behaviour
// - Polarity one: idle high, phase picks edges.
// - Polarity zero: idle low, phase picks edges.
// - Phase zero samples leading, one trailing.
// - Phase zero: first bit stable before edge.
// - Write: direction bit, address, data, MSB first.
// - Read: direction bit, address, then collect data.
// - Slave returns eight register bits on read.
//
// Slave end: holds 128 eight-bit registers reached over the link.
// Assumes the link wires are asynchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none
`include "sma_cfg.svh"

module sma_slave #(
    parameter int NREG = 128
) (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       cpol_i,
    input  wire logic       cpha_i,
    sma_if.slave            link,
    output logic            wr_pulse_o,
    output logic [6:0]      wr_addr_o,
    output logic [7:0]      wr_data_o
);
    typedef struct packed {
        logic [1:0] sclk_s;
        logic [1:0] cs_s;
        logic [1:0] mosi_s;
        logic       sclk_d;
        logic [4:0] bitn;
        logic [15:0] shift;
        logic [7:0] tx;
        logic       miso;
        logic       oe;
        logic       wr;
        logic [6:0] waddr;
        logic [7:0] wdata;
    } sma_slv_t;

    sma_slv_t st_reg;
    sma_slv_t st_next;
    logic [7:0] regs_reg [NREG];
    logic lead;
    logic trail;
    logic samp;
    logic launch;
    logic act;
    logic [6:0] fetch_addr;

    // ----------------------------------------------------------------
    // Edge classification
    // ----------------------------------------------------------------
    // Leading edge leaves the idle level set by polarity
    assign act    = !st_reg.cs_s[1];
    assign lead   = (st_reg.sclk_s[1] != st_reg.sclk_d)
                    && (st_reg.sclk_d == cpol_i);
    assign trail  = (st_reg.sclk_s[1] != st_reg.sclk_d)
                    && (st_reg.sclk_d != cpol_i);
    assign samp   = act && (cpha_i ? trail : lead);
    assign launch = act && (cpha_i ? lead : trail);
    // Read address completes with the bit sampled at this edge
    assign fetch_addr = {st_reg.shift[5:0], st_reg.mosi_s[1]};

    always_comb begin
        st_next = st_reg;
        st_next.sclk_s = {st_reg.sclk_s[0], link.sclk};
        st_next.cs_s   = {st_reg.cs_s[0], link.cs_b};
        st_next.mosi_s = {st_reg.mosi_s[0], link.mosi};
        st_next.sclk_d = st_reg.sclk_s[1];
        st_next.wr     = 1'b0;
        if (!act) begin
            st_next.bitn = '0;
            st_next.oe   = 1'b0;
        end else begin
            st_next.oe = 1'b1;
            if (samp) begin
                st_next.shift = {st_reg.shift[14:0], st_reg.mosi_s[1]};
                st_next.bitn  = st_reg.bitn + 5'd1;
                // Address complete: fetch read data
                if (st_reg.bitn == 5'd7) begin
                    st_next.tx = regs_reg[fetch_addr];
                end
                // Full write frame: dir, address, data
                if (st_reg.bitn == 5'd15 && st_reg.shift[14]
                        == `SMA_DIR_WRITE) begin
                    st_next.wr    = 1'b1;
                    st_next.waddr = st_reg.shift[13:7];
                    st_next.wdata = {st_reg.shift[6:0],
                                     st_reg.mosi_s[1]};
                end
            end
            // Launch MSB first during the data phase
            if (launch && st_reg.bitn >= 5'd8
                    && st_reg.bitn < 5'd16) begin
                st_next.miso = st_reg.tx[7];
                st_next.tx   = {st_reg.tx[6:0], 1'b0};
            end
            // Phase zero: first data bit out before first edge;
            // tx stays whole, the first trailing launch repeats it
            if (samp && !cpha_i && st_reg.bitn == 5'd7) begin
                st_next.miso = regs_reg[fetch_addr][7];
            end
        end
    end

    // Register array written by completed write frames
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < NREG; i++) begin
                regs_reg[i] <= `SMA_REG_RESET;
            end
        end else if (st_reg.wr) begin
            regs_reg[st_reg.waddr] <= st_reg.wdata;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
            st_reg.sclk_s <= 2'b00;
            st_reg.cs_s   <= 2'b11;
        end else begin
            st_reg <= st_next;
        end
    end

    assign link.miso    = st_reg.miso;
    assign link.miso_oe = st_reg.oe;
    assign wr_pulse_o   = st_reg.wr;
    assign wr_addr_o    = st_reg.waddr;
    assign wr_data_o    = st_reg.wdata;
endmodule

`default_nettype wire

// ### sma_master.sv
// Master end: takes commands through a FIFO and runs link frames.
// Assumes miso is asynchronous; sclk derived from clk_i by a divider.
`timescale 1ns/100ps
`default_nettype none
`include "sma_cfg.svh"

module sma_master #(
    parameter int HALF = `SMA_HALF_DIV
) (
    input  wire logic            clk_i,
    input  wire logic            rst_b_i,
    input  wire logic            cpol_i,
    input  wire logic            cpha_i,
    input  wire logic            cmd_valid_i,
    output logic                 cmd_ready_o,
    input  wire sma_pkg::sma_cmd_t cmd_i,
    sma_if.master                link,
    output logic                 rd_valid_o,
    output logic [7:0]           rd_data_o
);
    typedef enum logic [1:0] {S_IDLE, S_SETUP, S_RUN, S_END} sma_st_t;
    typedef struct packed {
        sma_st_t    st;
        logic [1:0] miso_s;
        logic [7:0] div;
        logic [5:0] edges;
        logic [15:0] tx;
        logic [7:0] rx;
        logic       rd;
        logic       pend;
        logic       sclk;
        logic       cs_b;
        logic       mosi;
        logic       rv;
        logic [7:0] rdata;
    } sma_mst_t;

    sma_mst_t st_reg;
    sma_mst_t st_next;
    logic       f_valid;
    logic       f_pop;
    logic [15:0] f_data;
    logic       lead;

    // ----------------------------------------------------------------
    // Command buffer: stalls the user when four are queued
    // ----------------------------------------------------------------
    sma_fifo #(.WIDTH(16), .DEPTH(4)) u_fifo (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .in_valid_i (cmd_valid_i),
        .in_ready_o (cmd_ready_o),
        .in_data_i  (cmd_i),
        .out_valid_o(f_valid),
        .out_ready_i(f_pop),
        .out_data_o (f_data)
    );

    assign f_pop = (st_reg.st == S_IDLE) && f_valid;
    assign lead  = !st_reg.edges[0];

    always_comb begin
        st_next = st_reg;
        st_next.miso_s = {st_reg.miso_s[0], link.miso};
        st_next.rv     = 1'b0;
        unique case (st_reg.st)
            S_IDLE: begin
                st_next.sclk = cpol_i;
                st_next.cs_b = 1'b1;
                if (f_valid) begin
                    st_next.tx   = f_data;
                    st_next.rd   = f_data[15];
                    st_next.cs_b = 1'b0;
                    st_next.mosi = f_data[15];
                    st_next.div  = '0;
                    st_next.edges = '0;
                    st_next.pend  = 1'b0;
                    st_next.st   = S_SETUP;
                end
            end
            S_SETUP: begin
                // Half period with data stable before first edge
                st_next.div = st_reg.div + 8'd1;
                if (st_reg.div == 8'(HALF - 1)) begin
                    st_next.div = '0;
                    st_next.st  = S_RUN;
                end
            end
            S_RUN: begin
                st_next.div = st_reg.div + 8'd1;
                if (st_reg.div == 8'(HALF - 1)) begin
                    st_next.div   = '0;
                    st_next.sclk  = !st_reg.sclk;
                    st_next.edges = st_reg.edges + 6'd1;
                    // Mark the capture on leading or trailing per phase
                    if (lead != cpha_i) begin
                        st_next.pend = 1'b1;
                    end
                    // Launch on the other edge, skip phase-0 first bit
                    if (lead == cpha_i) begin
                        st_next.mosi = cpha_i ? st_reg.tx[15]
                                              : st_reg.tx[14];
                        st_next.tx = {st_reg.tx[14:0], 1'b0};
                    end
                    if (st_reg.edges == 6'd31) begin
                        st_next.st = S_END;
                    end
                end
            end
            S_END: begin
                // Close frame after the final bit
                st_next.div = st_reg.div + 8'd1;
                if (st_reg.div == 8'(HALF - 1)) begin
                    st_next.cs_b  = 1'b1;
                    st_next.rv    = st_reg.rd;
                    st_next.rdata = st_reg.rx;
                    st_next.st    = S_IDLE;
                end
            end
        endcase
        // Capture late: the returned bit crosses two synchronisers
        // on each end, five cycles that a half period barely covers
        if (st_reg.pend && st_reg.div == 8'd1) begin
            st_next.rx   = {st_reg.rx[6:0], st_reg.miso_s[1]};
            st_next.pend = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg      <= '0;
            st_reg.cs_b <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign link.sclk  = st_reg.sclk;
    assign link.cs_b  = st_reg.cs_b;
    assign link.mosi  = st_reg.mosi;
    assign rd_valid_o = st_reg.rv;
    assign rd_data_o  = st_reg.rdata;
endmodule

`default_nettype wire

// ### sma_asserts.sv
// Checker on the link wires between the two ends.
// Assumes wires sampled on clk_i, divider of five.
`timescale 1ns/100ps
`default_nettype none

module sma_asserts (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic cpol_i,
    input wire logic cpha_i,
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    logic       sclk_q;
    logic [5:0] edge_cnt;
    logic [1:0] idle_cnt;
    logic       smp;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // ----
    // Edge and idle counters
    // ----
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sclk_q   <= 1'b0;
            edge_cnt <= 6'd0;
            idle_cnt <= 2'd0;
        end else begin
            sclk_q   <= sclk;
            edge_cnt <= cs_b ? 6'd0 : edge_cnt + 6'(sclk != sclk_q);
            idle_cnt <= !cs_b ? 2'd0 : idle_cnt + 2'(idle_cnt != 2'd3);
        end
    end
    // Capture edge: leading in phase 0, trailing in phase 1
    assign smp = !cs_b && sclk != sclk_q && (sclk != cpol_i) == !cpha_i;

    sequence s_hold3;
        ($stable(mosi) && $stable(sclk)) [*3];
    endsequence

    // ----
    // Wire rules
    // ----
    AST_IDLE_LEVEL:
    assert property (idle_cnt == 2'd3 |-> sclk == cpol_i)
        else $error("link clock off idle level");
    AST_HALF_STEP:
    assert property (!cs_b && $changed(sclk) |=> $stable(sclk) [*4])
        else $error("link clock stepped early");
    AST_PH0_SETUP:
    assert property ($fell(cs_b) && !cpha_i |=> s_hold3)
        else $error("first bit not held before first edge");
    AST_EDGES:
    assert property ($rose(cs_b) |-> edge_cnt == 6'd32)
        else $error("frame edge count wrong");
    AST_CS_GAP:
    assert property ($rose(cs_b) |-> sclk == cpol_i && $stable(sclk))
        else $error("select released with link clock not at rest");
    AST_MOSI_AT_EDGE:
    assert property (smp |-> $stable(mosi))
        else $error("mosi moved at capture edge");
    AST_MISO_AT_EDGE:
    assert property (smp && edge_cnt >= 6'd16 |-> $stable(miso))
        else $error("miso moved at capture edge");
    AST_OE_ON:
    assert property ($fell(cs_b) |-> ##[0:6] miso_oe)
        else $error("slave never drove miso");
endmodule

`default_nettype wire

// ### tb_top.sv
// Bench: both link ends joined, four clock modes, random traffic.
// Assumes the default divider and a four-deep command FIFO.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    logic              clk_i = 1'b0, rst_b_i = 1'b0;
    logic              cpol = 1'b0, cpha = 1'b0, cmd_vld = 1'b0;
    sma_pkg::sma_cmd_t cmd = '0;
    logic              cmd_rdy, rd_vld, wr_pls;
    logic [7:0]        rd_data, wr_data, mi_sh, mem [128];
    logic [6:0]        wr_addr;
    logic [15:0]       mo_sh, exp_mo [$], exp_wr [$];
    logic [7:0]        exp_rd [$];
    logic              sclk_q = 1'b0, cs_q = 1'b1;
    int                n_smp = 0, refused = 0;
    int                bad_count = 0, check_count = 0;

    sma_if u_sma_if ();
    sma_master u_sma_master (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .cpol_i(cpol), .cpha_i(cpha), .cmd_valid_i(cmd_vld),
        .cmd_ready_o(cmd_rdy), .cmd_i(cmd), .link(u_sma_if),
        .rd_valid_o(rd_vld), .rd_data_o(rd_data));
    sma_slave u_sma_slave (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .cpol_i(cpol), .cpha_i(cpha), .link(u_sma_if),
        .wr_pulse_o(wr_pls), .wr_addr_o(wr_addr), .wr_data_o(wr_data));
    sma_asserts u_sma_asserts (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .cpol_i(cpol), .cpha_i(cpha), .sclk(u_sma_if.sclk),
        .cs_b(u_sma_if.cs_b), .mosi(u_sma_if.mosi),
        .miso(u_sma_if.miso), .miso_oe(u_sma_if.miso_oe));

    always #4 clk_i = ~clk_i;

    task automatic check(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Queue one command; valid stays up so commands go back to back
    task automatic send(input logic rd, input logic [6:0] a,
                        input logic [7:0] d);
        int n;
        n = 0;
        exp_mo.push_back({rd, a, rd ? mem[a] : d});
        if (rd) begin
            exp_rd.push_back(mem[a]);
        end else begin
            exp_wr.push_back({1'b0, a, d});
            mem[a] = d;
        end
        cmd_vld <= 1'b1;
        cmd <= {rd, a, d};
        @(posedge clk_i);
        while (cmd_rdy !== 1'b1 && n < 3000) begin
            n++;
            refused++;
            @(posedge clk_i);
        end
        if (n >= 3000) begin
            check("cmd_ready", 16'd1, {15'd0, cmd_rdy});
        end
    endtask

    // Wire monitor: shift on capture edges, judge at select release
    // Looks at the falling clock edge, where the flops have settled
    always @(negedge clk_i) begin
        logic [15:0] f;
        if (rst_b_i && u_sma_if.cs_b && !cs_q) begin
            f = exp_mo.size() ? exp_mo.pop_front() : 'x;
            check("edges", 16'd16, 16'(n_smp));
            check("idle", {15'd0, cpol}, {15'd0, u_sma_if.sclk});
            check("frame", f, {mo_sh[15:8], f[15] ? mi_sh : mo_sh[7:0]});
        end
        if (u_sma_if.cs_b) begin
            n_smp = 0;
        end else if (sclk_q !== u_sma_if.sclk &&
                     (u_sma_if.sclk !== cpol) === !cpha) begin
            mo_sh = {mo_sh[14:0], u_sma_if.mosi};
            mi_sh = {mi_sh[6:0], u_sma_if.miso};
            n_smp++;
        end
        sclk_q = u_sma_if.sclk;
        cs_q = u_sma_if.cs_b;
    end

    // User-side results: read data and write commits, off the edge
    always @(negedge clk_i) begin
        if (rd_vld === 1'b1) begin
            check("rd_data", {8'd0, exp_rd.size() ? exp_rd.pop_front()
                  : 8'hxx}, {8'd0, rd_data});
        end
        if (wr_pls === 1'b1) begin
            check("commit", exp_wr.size() ? exp_wr.pop_front() : 'x,
                  {1'b0, wr_addr, wr_data});
        end
    end

    // Main sequence: each mode starts from reset, registers read 0x00
    initial begin
        logic [6:0] a;
        void'($urandom(34813));
        for (int m = 0; m < 4; m++) begin
            rst_b_i <= 1'b0;
            cpol <= m[1];
            cpha <= m[0];
            repeat (3) @(posedge clk_i);
            rst_b_i <= 1'b1;
            @(posedge clk_i);
            mem = '{default: 8'h00};
            refused = 0;
            send(1'b1, 7'h7f, 8'h00);
            send(1'b0, 7'h7f, 8'hff);
            send(1'b0, 7'h00, 8'h01);
            for (int i = 0; i < 4; i++) begin
                a = 7'($urandom);
                send(1'b0, a, 8'($urandom));
                send(1'b1, a, 8'($urandom));
            end
            send(1'b1, 7'h7f, 8'h00);
            send(1'b1, 7'h00, 8'h00);
            cmd_vld <= 1'b0;
            for (int i = 0; i < 3000 && exp_rd.size() > 0; i++) begin
                @(posedge clk_i);
            end
            repeat (20) @(posedge clk_i);
            check("left", 16'd0, 16'(exp_mo.size() + exp_wr.size()
                                     + exp_rd.size()));
            check("refused", 16'd1, {15'd0, refused > 0});
        end
        test_done();
    end

    // Watchdog: four modes of thirteen frames take about 10000 cycles
    initial begin
        repeat (30000) @(posedge clk_i);
        bad_count++;
        test_done();
    end
endmodule

`default_nettype wire
